// [pivm_pkg.sv]
// constants of the priority interrupt vector modifier
// Summary of operation
// - request vector fetch redirected to level vector
// - valid means level at or above mask
// - all other addresses pass unchanged
// - level vector access loads mask register
// - mask setting access itself not rewritten
// - capture requests each phase two, except in request and trap vectors
// - eight request lines, one per level
// - pulse latch set always, cleared by adapter
// - adapter bit raises comm controller interrupt
// - level n selects pair 2n above lowest
// - no valid request keeps default nibble
// - level seven highest, mask zero to seven
package pivm_pkg;

  localparam int unsigned NUM_LEVELS  = 8;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned LVL_W       = 3;
  localparam int unsigned NIB_W       = 4;

  // address field positions of the rewritten nibble
  localparam int unsigned NIB_LSB     = 1;
  localparam int unsigned NIB_MSB     = 4;

  // vector area: level vectors from lowest pair up to highest pair
  localparam logic [ADDR_W-1:0] LVL_VEC_LO  = 16'hFFE8;
  localparam logic [ADDR_W-1:0] LVL_VEC_HI  = 16'hFFF7;
  // request vector pair
  localparam logic [ADDR_W-1:0] REQ_VEC_LO  = 16'hFFF8;
  localparam logic [ADDR_W-1:0] REQ_VEC_HI  = 16'hFFF9;
  // request plus software trap vectors, capture suppressed here
  localparam logic [ADDR_W-1:0] HOLD_VEC_LO = 16'hFFF8;
  localparam logic [ADDR_W-1:0] HOLD_VEC_HI = 16'hFFFB;

  // nibble of the lowest level pair, and the default request nibble
  localparam logic [NIB_W-1:0]  NIB_LEVEL0  = 4'h4;
  localparam logic [NIB_W-1:0]  NIB_DEFAULT = 4'hC;

  // reset values
  localparam logic [LVL_W-1:0]  MASK_RST    = 3'h0;
  localparam logic [7:0]        REQ_RST     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST    = 16'h0000;

  // default set of request lines that pass through a pulse latch
  localparam logic [7:0]        LATCHED_DEF = 8'h01;

endpackage

// [pivm_top.sv]
// priority interrupt logic with vector address modifier and mask register
`timescale 1ns/100ps
module pivm_top #(
  parameter logic [7:0] LATCHED_LINES = pivm_pkg::LATCHED_DEF
) (
  // clock, reset, enable
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  // processor bus, same clock domain
  input  wire logic [pivm_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic                        cpu_vma,
  input  wire logic                        cpu_rw,
  input  wire logic                        cpu_phase2,
  // incoming request pins, asynchronous, active high
  input  wire logic [7:0]                  irq_req,
  // local parallel adapter bits
  input  wire logic                        adapter_latch_keep,
  input  wire logic                        adapter_comm_irq,
  // outputs toward processor and memory
  output logic [pivm_pkg::ADDR_W-1:0]      mod_addr,
  output logic                             cpu_irq_n,
  output logic                             comm_irq_n,
  output logic [pivm_pkg::LVL_W-1:0]       mask_level,
  output logic [7:0]                       int_reg,
  output logic                             vec_fetch
);

  // all state of the block except the reset synchroniser
  typedef struct packed {
    logic [7:0]                  sync1;
    logic [7:0]                  sync2;
    logic [7:0]                  sync3;
    logic [7:0]                  req;
    logic [7:0]                  latch;
    logic [7:0]                  intr;
    logic [pivm_pkg::LVL_W-1:0]  mask;
    logic                        ph2;
    logic [pivm_pkg::ADDR_W-1:0] addr;
    logic                        irq_n;
    logic                        comm_n;
    logic                        vfetch;
  } pivm_state_t;

  pivm_state_t st_q;
  pivm_state_t st_d;

  logic [1:0]  rst_sync_q;
  logic        rst_n;

  // combinational helpers
  logic                        in_lvl_area;
  logic                        in_req_vec;
  logic                        in_hold_vec;
  logic [7:0]                  eff_req;
  logic [7:0]                  valid;
  logic                        any_valid;
  logic [pivm_pkg::LVL_W-1:0]  top_lvl;
  logic [pivm_pkg::NIB_W-1:0]  lvl_nib;
  logic [pivm_pkg::NIB_W-1:0]  new_nib;
  logic                        ph2_start;

  // the level logic assumes exactly eight levels and a three bit mask
  if (pivm_pkg::NUM_LEVELS != 8 || pivm_pkg::LVL_W != 3) begin : g_chk
    $error("pivm_top serves eight levels only");
  end

  // with no latched line a short pulse could vanish before it is serviced
  if (LATCHED_LINES == 8'h00) begin : g_chk_latch
    $error("pivm_top needs at least one latched request line");
  end

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // address decode, only counted while the processor drives the bus
  // the hold window also covers the trap pair, so a trap fetch freezes capture too
  always_comb begin
    in_lvl_area = cpu_vma && (cpu_addr >= pivm_pkg::LVL_VEC_LO)
                  && (cpu_addr <= pivm_pkg::LVL_VEC_HI);
    in_req_vec  = cpu_vma && (cpu_addr >= pivm_pkg::REQ_VEC_LO)
                  && (cpu_addr <= pivm_pkg::REQ_VEC_HI);
    in_hold_vec = cpu_vma && (cpu_addr >= pivm_pkg::HOLD_VEC_LO)
                  && (cpu_addr <= pivm_pkg::HOLD_VEC_HI);
  end

  // request lines as seen by the interrupt register
  always_comb begin
    eff_req = (st_q.req & ~LATCHED_LINES) | (st_q.latch & LATCHED_LINES);
  end

  // valid requests and the highest of them
  // priority encoder: the upward loop leaves the highest valid level behind
  always_comb begin
    valid   = 8'h00;
    top_lvl = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (st_q.intr[i] && (i >= int'(st_q.mask))) begin
        valid[i] = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (valid[i]) begin
        top_lvl = i[2:0];
      end
    end
    any_valid = |valid;
    // level n sits 2n cells above the lowest pair
    lvl_nib   = pivm_pkg::NIB_LEVEL0 + {1'b0, top_lvl};
  end

  // nibble on address lines four to one
  always_comb begin
    new_nib = cpu_addr[pivm_pkg::NIB_MSB:pivm_pkg::NIB_LSB];
    if (in_req_vec && any_valid) begin
      new_nib = lvl_nib;
    end else if (in_req_vec) begin
      new_nib = pivm_pkg::NIB_DEFAULT;
    end
  end

  // phase two start, seen as a rise of the phase qualifier
  // the previous sample resets low, so the first phase after reset may look
  // like a start; the request chain is still empty then, so nothing is lost
  always_comb begin
    ph2_start = cpu_phase2 && !st_q.ph2;
  end

  // next state
  always_comb begin
    st_d = st_q;

    // three stage synchroniser, a change counts once stages agree
    // so a metastable first stage can never reach the interrupt register
    st_d.sync1 = irq_req;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < 8; i++) begin
      if (st_q.sync2[i] == st_q.sync3[i]) begin
        st_d.req[i] = st_q.sync3[i];
      end
    end

    // pulse latch: a request always sets it, even while clearing
    // a line outside the latched set passes straight and keeps its latch at zero
    for (int i = 0; i < 8; i++) begin
      if (LATCHED_LINES[i]) begin
        if (st_q.req[i]) begin
          st_d.latch[i] = 1'b1;
        end else if (!adapter_latch_keep) begin
          st_d.latch[i] = 1'b0;
        end
      end else begin
        st_d.latch[i] = 1'b0;
      end
    end

    st_d.ph2 = cpu_phase2;

    // capture frozen during vector fetch so the nibble stays stable
    if (ph2_start && !in_hold_vec) begin
      st_d.intr = eff_req;
    end

    // any read or write in the level area loads its level
    // a write sets the mask without disturbing processor registers
    if (in_lvl_area) begin
      st_d.mask = 3'(cpu_addr[pivm_pkg::NIB_MSB:pivm_pkg::NIB_LSB]
                  - pivm_pkg::NIB_LEVEL0);
    end

    // only bits four to one ever change; level area passes as is
    st_d.addr = {cpu_addr[pivm_pkg::ADDR_W-1:pivm_pkg::NIB_MSB+1],
                 new_nib,
                 cpu_addr[0]};

    st_d.irq_n  = !any_valid;
    st_d.comm_n = !adapter_comm_irq;
    st_d.vfetch = in_req_vec;
  end

  // state register, frozen while the enable is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.sync1  <= pivm_pkg::REQ_RST;
      st_q.sync2  <= pivm_pkg::REQ_RST;
      st_q.sync3  <= pivm_pkg::REQ_RST;
      st_q.req    <= pivm_pkg::REQ_RST;
      st_q.latch  <= pivm_pkg::REQ_RST;
      st_q.intr   <= pivm_pkg::REQ_RST;
      st_q.mask   <= pivm_pkg::MASK_RST;
      st_q.ph2    <= 1'b0;
      st_q.addr   <= pivm_pkg::ADDR_RST;
      st_q.irq_n  <= 1'b1;
      st_q.comm_n <= 1'b1;
      st_q.vfetch <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  // registering the address costs a cycle but keeps decode glitches off memory
  assign mod_addr   = st_q.addr;
  assign cpu_irq_n  = st_q.irq_n;
  assign comm_irq_n = st_q.comm_n;
  assign mask_level = st_q.mask;
  assign int_reg    = st_q.intr;
  assign vec_fetch  = st_q.vfetch;

  // cpu_rw is unused: mask setting acts on reads and writes alike
  logic unused_rw;
  assign unused_rw = cpu_rw;

endmodule

// [pivm_cpu_model.sv]
// processor side model: free running phase two and single bus accesses
`timescale 1ns/100ps
module pivm_cpu_model (
  // clock
  input  wire logic        ref_clk,
  // processor bus
  output logic      [15:0] cpu_addr,
  output logic             cpu_vma,
  output logic             cpu_rw,
  output logic             cpu_phase2
);
  logic [1:0] ph = 2'h0;
  initial begin
    cpu_addr = 16'h0000;
    cpu_vma  = 1'b0;
    cpu_rw   = 1'b1;
  end
  // phase two high for two of every four cycles
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    cpu_phase2 <= #1 ph[1];
  end
  // one access cycle; a released bus shows the inverted address, not a stale one
  task access(input logic [15:0] a, input logic rw);
    @(posedge ref_clk) #1;
    cpu_addr = a;
    cpu_vma  = 1'b1;
    cpu_rw   = rw;
    @(posedge ref_clk) #1;
    cpu_vma  = 1'b0;
    cpu_addr = ~a;
    cpu_rw   = 1'b1;
  endtask
endmodule

// [pivm_checker.sv]
// concurrent checks on the ports of the interrupt vector modifier
`timescale 1ns/100ps
module pivm_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // inputs
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_vma,
  input wire logic        cpu_phase2,
  input wire logic        adapter_comm_irq,
  // outputs
  input wire logic [15:0] mod_addr,
  input wire logic        cpu_irq_n,
  input wire logic        comm_irq_n,
  input wire logic [2:0]  mask_level,
  input wire logic [7:0]  int_reg,
  input wire logic        vec_fetch
);
  logic [3:0] nib;
  logic       fetch, setm, hold, anyv;
  // highest valid level wins, since the loop runs upward
  always_comb begin
    nib = 4'hC;
    for (int i = 0; i < 8; i++)
      if (int_reg[i] && i >= int'(mask_level)) nib = 4'(4 + i);
  end
  assign anyv  = |(int_reg & (8'hFF << mask_level));
  assign fetch = cpu_vma && cpu_addr[15:1] == 15'h7FFC;
  assign setm  = cpu_vma && cpu_addr >= 16'hFFE8 && cpu_addr <= 16'hFFF7;
  assign hold  = cpu_vma && cpu_addr[15:2] == 14'h3FFE;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_vec_rewrite: assert property (fetch |=> mod_addr == {$past(cpu_addr[15:5]), $past(nib),
    $past(cpu_addr[0])}) else $error("vector address not rewritten");
  a_other_pass: assert property (!fetch |=> mod_addr == $past(cpu_addr))
    else $error("address modified outside vector fetch");
  a_mask_load: assert property (setm |=> mask_level == 3'($past(cpu_addr[4:1]) - 4'h4))
    else $error("mask not loaded from vector address");
  a_mask_hold: assert property (!setm |=> $stable(mask_level))
    else $error("mask changed without access");
  a_irq_level: assert property (cpu_irq_n == !$past(anyv))
    else $error("request output disagrees with valid set");
  a_capture_hold: assert property (hold |=> $stable(int_reg))
    else $error("interrupt register loaded during vector fetch");
  a_capture_edge: assert property ($changed(int_reg) |-> $past(cpu_phase2) &&
    !$past(cpu_phase2, 2)) else $error("interrupt register loaded off phase two start");
  a_comm_follow: assert property (comm_irq_n == !$past(adapter_comm_irq))
    else $error("comm interrupt does not follow adapter bit");
  a_fetch_flag: assert property (vec_fetch == $past(fetch))
    else $error("fetch flag does not follow request vector access");
  c_fetch_valid: cover property (fetch && anyv);
  c_mask_set: cover property (setm);
  c_irq_low: cover property (!cpu_irq_n);
endmodule
bind pivm_top pivm_checker i_pivm_checker (.ref_clk(ref_clk), .arst_n(arst_n),
  .cpu_addr(cpu_addr), .cpu_vma(cpu_vma), .cpu_phase2(cpu_phase2),
  .adapter_comm_irq(adapter_comm_irq), .mod_addr(mod_addr), .cpu_irq_n(cpu_irq_n),
  .comm_irq_n(comm_irq_n), .mask_level(mask_level), .int_reg(int_reg), .vec_fetch(vec_fetch));

// [pivm_tb.sv]
// self-checking bench of the interrupt vector modifier
`timescale 1ns/100ps
module pivm_tb;
  logic ref_clk = 1'b0, arst_n = 1'b0, keep = 1'b0, comm = 1'b0, clk_en = 1'b1, vma, rw, ph2;
  logic [15:0] addr, mod_addr, a;
  logic [7:0]  irq_req = 8'h00, int_reg, r;
  logic [2:0]  mask_level, m;
  logic        cpu_irq_n, comm_irq_n, vec_fetch;
  int          errors = 0, checks = 0, seed = 46;
  always #4 ref_clk = ~ref_clk;
  pivm_top i_pivm_top (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .cpu_addr(addr),
    .cpu_vma(vma), .cpu_rw(rw), .cpu_phase2(ph2), .irq_req(irq_req),
    .adapter_latch_keep(keep), .adapter_comm_irq(comm), .mod_addr(mod_addr),
    .cpu_irq_n(cpu_irq_n), .comm_irq_n(comm_irq_n), .mask_level(mask_level),
    .int_reg(int_reg), .vec_fetch(vec_fetch));
  pivm_cpu_model i_pivm_cpu_model (.ref_clk(ref_clk), .cpu_addr(addr), .cpu_vma(vma),
    .cpu_rw(rw), .cpu_phase2(ph2));
  // expected memory address for a bus address, request set and mask
  function automatic logic [15:0] exp_addr(logic [15:0] x, logic [7:0] q, logic [2:0] k);
    logic [3:0] n;
    n = 4'hC;
    for (int i = 0; i < 8; i++)
      if (q[i] && i >= int'(k)) n = 4'(4 + i);
    return (x[15:1] == 15'h7FFC) ? {x[15:5], n, x[0]} : x;
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog far beyond the expected run of some 540 cycles
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    wait_cyc(3);
    arst_n = 1'b1;
    wait_cyc(3);
    chk(mod_addr, 16'h0000);
    chk({cpu_irq_n, mask_level, int_reg}, 12'h800);
    $display("test reset done");
    // random requests and masks, with no-request and all-request corners first
    for (int k = 0; k < 24; k++) begin
      a = {1'b0, 15'($random(seed))};
      i_pivm_cpu_model.access(a, 1'b1);
      chk(mod_addr, a);
      chk(vec_fetch, 1'b0);
      m = 3'($random(seed));
      r = 8'($random(seed));
      if (k == 0) r = 8'h00;
      if (k == 1) begin
        m = 3'h7;
        r = 8'hFF;
      end
      a = 16'hFFE8 + {12'h000, m, 1'($random(seed))}; // either cell of level m
      i_pivm_cpu_model.access(a, 1'(k));
      chk(mod_addr, a);
      irq_req = r;
      wait_cyc(12);
      chk(int_reg, r);
      chk(mask_level, m);
      chk(cpu_irq_n, !(|(r & (8'hFF << m))));
      for (int b = 0; b < 2; b++) begin
        i_pivm_cpu_model.access(16'hFFF8 + 16'(b), 1'b1);
        chk(mod_addr, exp_addr(16'hFFF8 + 16'(b), r, m));
        chk(vec_fetch, 1'b1);
      end
    end
    $display("test vectors done");
    // short pulse on the latched line must survive until the adapter clears it
    irq_req = 8'h01;
    keep = 1'b1;
    wait_cyc(4);
    irq_req = 8'h00;
    wait_cyc(12);
    chk(int_reg, 8'h01);
    keep = 1'b0;
    wait_cyc(12);
    chk(int_reg, 8'h00);
    $display("test latch done");
    comm = 1'b1;
    wait_cyc(2);
    chk(comm_irq_n, 1'b0);
    comm = 1'b0;
    wait_cyc(2);
    chk(comm_irq_n, 1'b1);
    $display("test comm done");
    // enable low freezes all state; eight cycles keep the phase detector in step
    clk_en = 1'b0;
    irq_req = 8'h80;
    wait_cyc(8);
    chk(int_reg, 8'h00);
    clk_en = 1'b1;
    wait_cyc(12);
    chk(int_reg, 8'h80);
    chk(cpu_irq_n, 1'b0);
    $display("test enable done");
    print_verdict();
  end
endmodule
